// >>> hdl/edge_catch.sv
// synchronised, edge selectable request catcher for one external line
`timescale 1ns/100ps

module edge_catch (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin,
	input  wire logic rising,
	input  wire logic clear,
	output logic      pending
);

	vectoring_pkg::edge_state_s s;
	vectoring_pkg::edge_state_s next_s;
	logic                       hit;

	// ----------------------------------------------------------------
	// synchroniser, edge detect, sticky pending
	// ----------------------------------------------------------------
	always_comb begin
		next_s      = s;
		next_s.s1   = pin;
		next_s.s2   = s.s1;
		next_s.prev = s.s2;
		hit         = rising ? (s.s2 & ~s.prev) : (~s.s2 & s.prev);
		next_s.pend = hit | (s.pend & ~clear); // new edge beats the clear
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pending = s.pend;

endmodule // edge_catch

// >>> hdl/interrupt_vectoring_unit.sv
// interrupt acceptance, context save and vector fetch sequencer
// Operation
// - take peripheral, pin and top level requests; save status, enter service routine
// - eight external channels, each with software selected trigger edge
// - top level channel fed by the non-maskable pin or the watchdog
// - acknowledged peripheral supplies the vector selecting the table entry
// - vector table is the first 256 bytes of the interrupt segment
// - software sets vector upper bits, hardware drives the lower bits
// - after reset fetch the start address from physical bytes zero and one
// - top level vector fetched from 0004/0005 of the interrupt segment
// - divide by zero vector fetched from 0002/0003 of the code segment
// - divide by zero trap pushes no flags; handler ends with plain return
// - segment save enable picks compatible or extended stack frame
// - save disabled: interrupt segment replaces code segment, push pc and flags
// - compatible mode: code segment writes ignored inside service routines
// - entry: clear enable, push pc low, pc high, segment, flags, load vector
// - return: pop flags, segment, pc high, pc low, then set enable
// - save enabled: push old code segment, then load it from interrupt segment
// - acknowledge only if level strictly below cpu level; top level overrides
`timescale 1ns/100ps

module interrupt_vectoring_unit (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [7:0]                      reg_rdata,
	input  wire logic [15:0]                core_pc,
	input  wire logic [7:0]                 core_flags,
	input  wire logic                       div_zero,
	input  wire logic                       iret,
	input  wire logic                       csr_wr,
	input  wire logic [7:0]                 csr_wdata,
	output logic [15:0]                     pc_value,
	output logic                            pc_load,
	output logic [7:0]                      flags_value,
	output logic                            flags_load,
	output logic                            busy,
	output logic [7:0]                      code_seg,
	output vectoring_pkg::mem_req_s         mem_req,
	input  wire logic [7:0]                 mem_rdata,
	input  wire logic [3:0]                 periph_req,
	input  wire logic [3:0][2:0]            periph_prl,
	input  wire logic [3:0][7:0]            periph_vec,
	output logic [3:0]                      periph_ack,
	input  wire logic [7:0]                 ext_pin,
	input  wire logic                       nmi_pin,
	input  wire logic                       wdg_req,
	output logic                            irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		vectoring_pkg::seq_state_e  st;
		vectoring_pkg::entry_kind_e kind;
		logic                       global_irq_enable;
		logic [2:0]                 cpu_priority_level;
		logic                       tl_src;
		logic                       sse;
		logic [7:0]                 iseg;
		logic [7:0]                 cseg;
		logic [7:0]                 edge_sel;
		logic [7:0]                 ext_en;
		logic [3:0]                 vec_base;
		logic [2:0]                 ext_prl;
		logic [2:0]                 status;
		logic [2:0]                 mask;
		logic [15:0]                sp;
		logic [15:0]                pc;
		logic [7:0]                 flags;
		logic [7:0]                 pop_cs;
		logic [23:0]                vaddr;
		logic [3:0]                 depth;
		logic                       tl_active;
		logic                       wdg_pend;
		logic                       nmi_clr;
		logic [7:0]                 ext_clr;
		logic [3:0]                 ack;
		logic                       pc_load;
		logic                       flags_load;
		logic [7:0]                 rdata;
		vectoring_pkg::mem_req_s    mem;
	} unit_state_s;

	unit_state_s s;
	unit_state_s next_s;
	logic [7:0]  ext_pend;
	logic        nmi_pend;
	logic        tl_req;
	logic        best_hit;
	logic [2:0]  best_prl;
	logic [7:0]  best_vec;
	logic [11:0] best_onehot;
	logic [2:0]  events;
	logic        compat_isr;

	// ----------------------------------------------------------------
	// external and non-maskable line catchers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < vectoring_pkg::N_EXT; g++) begin : g_ext
		edge_catch u_ext (
			.clk     (clk),
			.resetn  (resetn),
			.pin     (ext_pin[g]),
			.rising  (s.edge_sel[g]),
			.clear   (s.ext_clr[g]),
			.pending (ext_pend[g])
		);
	end

	edge_catch u_nmi (
		.clk     (clk),
		.resetn  (resetn),
		.pin     (nmi_pin),
		.rising  (1'b1),
		.clear   (s.nmi_clr),
		.pending (nmi_pend)
	);

	// top level source selection
	assign tl_req     = (s.tl_src ? s.wdg_pend : nmi_pend) & ~s.tl_active;
	assign compat_isr = (s.depth != 4'h0) && !s.sse;

	// ----------------------------------------------------------------
	// arbitration: lowest level wins, lower index breaks ties
	// ----------------------------------------------------------------
	always_comb begin
		best_hit    = 1'b0;
		best_prl    = 3'h7;
		best_vec    = 8'h00;
		best_onehot = 12'h000;
		for (int i = 0; i < vectoring_pkg::N_PERIPH; i++) begin
			if (periph_req[i] && (!best_hit || periph_prl[i] < best_prl)) begin
				best_hit    = 1'b1;
				best_prl    = periph_prl[i];
				best_vec    = periph_vec[i];
				best_onehot = 12'h001 << i;
			end
		end
		for (int j = 0; j < vectoring_pkg::N_EXT; j++) begin
			if (ext_pend[j] && s.ext_en[j] && (!best_hit || s.ext_prl < best_prl)) begin
				best_hit    = 1'b1;
				best_prl    = s.ext_prl;
				best_vec    = {s.vec_base, j[2:0], 1'b0};
				best_onehot = 12'h010 << j;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer and register file
	// ----------------------------------------------------------------
	always_comb begin
		next_s            = s;
		next_s.ack        = 4'h0;
		next_s.ext_clr    = 8'h00;
		next_s.nmi_clr    = 1'b0;
		next_s.pc_load    = 1'b0;
		next_s.flags_load = 1'b0;
		next_s.mem        = '0;
		next_s.wdg_pend   = s.wdg_pend | wdg_req;
		events            = 3'h0;
		// register writes, only the bus changes these outside the sequencer
		if (reg_wr) begin
			case (reg_addr)
				vectoring_pkg::OFS_CENTRAL: begin
					next_s.global_irq_enable    = reg_wdata[vectoring_pkg::CTRL_IEN];
					next_s.cpu_priority_level    = reg_wdata[vectoring_pkg::CTRL_CPL_LO +: 3];
					next_s.tl_src = reg_wdata[vectoring_pkg::CTRL_TL_SRC];
				end
				vectoring_pkg::OFS_EXTMODE: next_s.sse = reg_wdata[vectoring_pkg::EMR_SSE];
				vectoring_pkg::OFS_ISEG:    next_s.iseg     = reg_wdata;
				vectoring_pkg::OFS_EDGE:    next_s.edge_sel = reg_wdata;
				vectoring_pkg::OFS_EXT_EN:  next_s.ext_en   = reg_wdata;
				vectoring_pkg::OFS_VECTOR:  next_s.vec_base = reg_wdata[7:vectoring_pkg::VEC_BASE_LO];
				vectoring_pkg::OFS_EXT_PRL: next_s.ext_prl  = reg_wdata[2:0];
				vectoring_pkg::OFS_MASK:    next_s.mask     = reg_wdata[2:0];
				vectoring_pkg::OFS_SP_LO:   next_s.sp[7:0]  = reg_wdata;
				vectoring_pkg::OFS_SP_HI:   next_s.sp[15:8] = reg_wdata;
				default: ;
			endcase
		end
		// core writes to the code segment, dropped while the interrupt segment stands in
		if (csr_wr && !compat_isr) begin
			next_s.cseg = csr_wdata;
		end
		case (s.st)
			vectoring_pkg::ST_IDLE: begin
				if (iret) begin
					next_s.st = vectoring_pkg::ST_POP_FL;
				end else if (div_zero) begin
					next_s.kind  = vectoring_pkg::KIND_TRAP;
					next_s.pc    = core_pc;
					next_s.vaddr = {s.cseg, vectoring_pkg::TRAP_VEC_OFS};
					next_s.st    = vectoring_pkg::ST_PUSH_PCL;
					events[vectoring_pkg::EV_TRAP] = 1'b1;
				end else if (tl_req) begin
					next_s.kind      = vectoring_pkg::KIND_TL;
					next_s.global_irq_enable       = 1'b0;
					next_s.pc        = core_pc;
					next_s.flags     = core_flags;
					next_s.tl_active = 1'b1;
					next_s.nmi_clr   = ~s.tl_src;
					next_s.wdg_pend  = wdg_req & s.tl_src;
					next_s.vaddr     = {s.iseg, vectoring_pkg::TL_VEC_OFS};
					next_s.depth     = s.depth + 4'h1;
					next_s.st        = vectoring_pkg::ST_PUSH_PCL;
					events[vectoring_pkg::EV_TL] = 1'b1;
				end else if (s.global_irq_enable && best_hit && best_prl < s.cpu_priority_level) begin
					next_s.kind    = vectoring_pkg::KIND_IRQ;
					next_s.global_irq_enable     = 1'b0;
					next_s.pc      = core_pc;
					next_s.flags   = core_flags;
					next_s.ack     = best_onehot[3:0];
					next_s.ext_clr = best_onehot[11:4];
					next_s.vaddr   = {s.iseg, vectoring_pkg::TABLE_PAGE, best_vec};
					next_s.depth   = s.depth + 4'h1;
					next_s.st      = vectoring_pkg::ST_PUSH_PCL;
					events[vectoring_pkg::EV_IRQ] = 1'b1;
				end
			end
			vectoring_pkg::ST_PUSH_PCL: next_s.st = vectoring_pkg::ST_PUSH_PCH;
			vectoring_pkg::ST_PUSH_PCH: begin
				if (s.kind == vectoring_pkg::KIND_TRAP) begin
					next_s.st = vectoring_pkg::ST_VEC_RD0;
				end else if (s.sse) begin
					next_s.st = vectoring_pkg::ST_PUSH_CS;
				end else begin
					next_s.st = vectoring_pkg::ST_PUSH_FL;
				end
			end
			vectoring_pkg::ST_PUSH_CS: next_s.st = vectoring_pkg::ST_PUSH_FL;
			vectoring_pkg::ST_PUSH_FL: next_s.st = vectoring_pkg::ST_VEC_RD0;
			vectoring_pkg::ST_VEC_RD0: next_s.st = vectoring_pkg::ST_VEC_RD1;
			vectoring_pkg::ST_VEC_RD1: begin
				next_s.pc[15:8] = mem_rdata;
				next_s.st       = vectoring_pkg::ST_VEC_LOAD;
			end
			vectoring_pkg::ST_VEC_LOAD: begin
				next_s.pc[7:0] = mem_rdata;
				next_s.pc_load = 1'b1;
				if (s.sse && s.kind != vectoring_pkg::KIND_TRAP && s.kind != vectoring_pkg::KIND_RST) begin
					next_s.cseg = s.iseg;
				end
				next_s.st = vectoring_pkg::ST_IDLE;
			end
			vectoring_pkg::ST_POP_FL: begin
				next_s.st = s.sse ? vectoring_pkg::ST_POP_CS : vectoring_pkg::ST_POP_PCH;
			end
			vectoring_pkg::ST_POP_CS: begin
				next_s.flags = mem_rdata;
				next_s.st    = vectoring_pkg::ST_POP_PCH;
			end
			vectoring_pkg::ST_POP_PCH: begin
				if (s.sse) begin
					next_s.pop_cs = mem_rdata;
				end else begin
					next_s.flags = mem_rdata;
				end
				next_s.st = vectoring_pkg::ST_POP_PCL;
			end
			vectoring_pkg::ST_POP_PCL: begin
				next_s.pc[15:8] = mem_rdata;
				next_s.st       = vectoring_pkg::ST_POP_END;
			end
			vectoring_pkg::ST_POP_END: begin
				next_s.pc[7:0]    = mem_rdata;
				next_s.pc_load    = 1'b1;
				next_s.flags_load = 1'b1;
				next_s.global_irq_enable        = 1'b1;
				next_s.tl_active  = 1'b0;
				next_s.depth      = (s.depth == 4'h0) ? 4'h0 : s.depth - 4'h1;
				if (s.sse) begin
					next_s.cseg = s.pop_cs;
				end
				next_s.st = vectoring_pkg::ST_IDLE;
			end
			default: next_s.st = vectoring_pkg::ST_IDLE;
		endcase
		// memory operation of the state being entered
		case (next_s.st)
			vectoring_pkg::ST_PUSH_PCL, vectoring_pkg::ST_PUSH_PCH,
			vectoring_pkg::ST_PUSH_CS, vectoring_pkg::ST_PUSH_FL: begin
				next_s.sp        = s.sp - 16'h0001;
				next_s.mem.wr    = 1'b1;
				next_s.mem.addr  = {vectoring_pkg::STACK_SEG, next_s.sp};
				if (next_s.st == vectoring_pkg::ST_PUSH_PCL) begin
					next_s.mem.wdata = next_s.pc[7:0];
				end else if (next_s.st == vectoring_pkg::ST_PUSH_PCH) begin
					next_s.mem.wdata = next_s.pc[15:8];
				end else if (next_s.st == vectoring_pkg::ST_PUSH_CS) begin
					next_s.mem.wdata = s.cseg;
				end else begin
					next_s.mem.wdata = s.flags;
				end
			end
			vectoring_pkg::ST_VEC_RD0: begin
				next_s.mem.rd   = 1'b1;
				next_s.mem.addr = s.vaddr;
			end
			vectoring_pkg::ST_VEC_RD1: begin
				next_s.mem.rd   = 1'b1;
				next_s.mem.addr = s.vaddr + 24'h000001;
			end
			vectoring_pkg::ST_POP_FL, vectoring_pkg::ST_POP_CS,
			vectoring_pkg::ST_POP_PCH, vectoring_pkg::ST_POP_PCL: begin
				next_s.mem.rd   = 1'b1;
				next_s.mem.addr = {vectoring_pkg::STACK_SEG, s.sp};
				next_s.sp       = s.sp + 16'h0001;
			end
			default: ;
		endcase
		// sticky events: a new event wins over a clear
		next_s.status = (s.status & ~((reg_wr && reg_addr == vectoring_pkg::OFS_STATUS) ?
			reg_wdata[2:0] : 3'h0)) | events;
		// register read data for the next cycle
		next_s.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				vectoring_pkg::OFS_CENTRAL: next_s.rdata = {3'h0, s.tl_src, s.cpu_priority_level, s.global_irq_enable};
				vectoring_pkg::OFS_EXTMODE: next_s.rdata = {7'h00, s.sse};
				vectoring_pkg::OFS_ISEG:    next_s.rdata = s.iseg;
				vectoring_pkg::OFS_CSEG:    next_s.rdata = s.cseg;
				vectoring_pkg::OFS_EDGE:    next_s.rdata = s.edge_sel;
				vectoring_pkg::OFS_EXT_EN:  next_s.rdata = s.ext_en;
				vectoring_pkg::OFS_VECTOR:  next_s.rdata = {s.vec_base, 4'h0};
				vectoring_pkg::OFS_EXT_PRL: next_s.rdata = {5'h00, s.ext_prl};
				vectoring_pkg::OFS_PENDING: next_s.rdata = ext_pend;
				vectoring_pkg::OFS_STATUS:  next_s.rdata = {5'h00, s.status};
				vectoring_pkg::OFS_MASK:    next_s.rdata = {5'h00, s.mask};
				vectoring_pkg::OFS_SP_LO:   next_s.rdata = s.sp[7:0];
				vectoring_pkg::OFS_SP_HI:   next_s.rdata = s.sp[15:8];
				default:                    next_s.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register; reset starts the start address fetch
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s          <= '0;
			s.st       <= vectoring_pkg::ST_VEC_RD0;
			s.kind     <= vectoring_pkg::KIND_RST;
			s.cpu_priority_level      <= vectoring_pkg::CPL_RESET;
			s.iseg     <= vectoring_pkg::ISEG_RESET;
			s.cseg     <= vectoring_pkg::CSEG_RESET;
			s.sp       <= vectoring_pkg::SP_RESET;
			s.vaddr    <= vectoring_pkg::RST_VEC_ADDR;
			s.mem.rd   <= 1'b1;
			s.mem.addr <= vectoring_pkg::RST_VEC_ADDR;
		end else begin
			s <= next_s;
		end
	end

	// outputs
	assign reg_rdata   = s.rdata;
	assign pc_value    = s.pc;
	assign pc_load     = s.pc_load;
	assign flags_value = s.flags;
	assign flags_load  = s.flags_load;
	assign busy        = (s.st != vectoring_pkg::ST_IDLE);
	assign code_seg    = compat_isr ? s.iseg : s.cseg;
	assign mem_req     = s.mem;
	assign periph_ack  = s.ack;
	assign irq         = |(s.status & s.mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_prio_strict: assert property ((s.st == vectoring_pkg::ST_IDLE && !iret && !div_zero
		&& !tl_req && |best_onehot[3:0] && s.global_irq_enable && best_prl >= s.cpu_priority_level) |=> periph_ack == 4'h0)
		else $error("channel acknowledged without strictly lower level");
	a_entry_ien: assert property ($rose(s.depth != 4'h0) |-> !s.global_irq_enable)
		else $error("enable not cleared on entry");
	a_push_order: assert property (s.st == vectoring_pkg::ST_PUSH_PCL |=> s.st == vectoring_pkg::ST_PUSH_PCH
		&& mem_req.wr && mem_req.wdata == s.pc[15:8])
		else $error("pc high byte not pushed after low byte");
	a_frame_cs: assert property ((s.st == vectoring_pkg::ST_PUSH_PCH && s.kind != vectoring_pkg::KIND_TRAP)
		|=> (s.st == vectoring_pkg::ST_PUSH_CS) == $past(s.sse))
		else $error("segment push does not follow save enable");
	a_trap_noflags: assert property ((s.st == vectoring_pkg::ST_PUSH_PCH && s.kind == vectoring_pkg::KIND_TRAP)
		|=> s.st == vectoring_pkg::ST_VEC_RD0 ##1 s.st == vectoring_pkg::ST_VEC_RD1)
		else $error("trap pushed more than the pc");
	a_trap_vector: assert property ((s.st == vectoring_pkg::ST_IDLE && div_zero && !iret)
		|-> ##3 mem_req.rd && mem_req.addr == {$past(s.cseg, 3), vectoring_pkg::TRAP_VEC_OFS})
		else $error("trap vector not read from code segment");
	a_tl_vector: assert property ((s.st == vectoring_pkg::ST_VEC_RD0 && s.kind == vectoring_pkg::KIND_TL)
		|-> mem_req.addr == {s.iseg, vectoring_pkg::TL_VEC_OFS})
		else $error("top level vector address wrong");
	a_cs_reload: assert property ((s.st == vectoring_pkg::ST_VEC_LOAD && s.kind == vectoring_pkg::KIND_IRQ
		&& s.sse) |=> s.cseg == $past(s.iseg) && pc_load)
		else $error("code segment not loaded from interrupt segment");
	a_iret_ien: assert property (s.st == vectoring_pkg::ST_POP_END |=> s.global_irq_enable && pc_load && flags_load)
		else $error("return did not restore enable and context");
	a_compat_seg: assert property ((s.depth != 4'h0 && !s.sse) |-> code_seg == s.iseg)
		else $error("interrupt segment not used in compatible mode");

	c_irq_entry: cover property (s.st == vectoring_pkg::ST_IDLE ##1 s.st == vectoring_pkg::ST_PUSH_PCL
		&& s.kind == vectoring_pkg::KIND_IRQ);
	c_ext_frame: cover property (s.st == vectoring_pkg::ST_PUSH_CS);
	c_trap: cover property (s.st == vectoring_pkg::ST_VEC_RD0 && s.kind == vectoring_pkg::KIND_TRAP);
	c_return: cover property (s.st == vectoring_pkg::ST_POP_END);

endmodule // interrupt_vectoring_unit

// >>> hdl/vectoring_pkg.sv
// constants, state encodings and carrier structs of the interrupt vectoring unit
package vectoring_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CENTRAL = 8'h00; // central_irq_control_reg
	localparam logic [7:0] OFS_EXTMODE = 8'h01; // extended_mode_reg_two
	localparam logic [7:0] OFS_ISEG    = 8'h02; // interrupt_segment_reg
	localparam logic [7:0] OFS_CSEG    = 8'h03; // code_segment_reg
	localparam logic [7:0] OFS_EDGE    = 8'h04; // external trigger edge select
	localparam logic [7:0] OFS_EXT_EN  = 8'h05; // external channel enable
	localparam logic [7:0] OFS_VECTOR  = 8'h06; // peripheral_vector_reg of external group
	localparam logic [7:0] OFS_EXT_PRL = 8'h07; // channel_priority_level of external group
	localparam logic [7:0] OFS_PENDING = 8'h08; // external pending, read only
	localparam logic [7:0] OFS_STATUS  = 8'h09; // event status, write one to clear
	localparam logic [7:0] OFS_MASK    = 8'h0a; // event mask
	localparam logic [7:0] OFS_SP_LO   = 8'h0b; // system stack pointer low
	localparam logic [7:0] OFS_SP_HI   = 8'h0c; // system stack pointer high

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_IEN     = 0; // global_irq_enable
	localparam int CTRL_CPL_LO  = 1; // cpu_priority_level, three bits
	localparam int CTRL_TL_SRC  = 4; // top level source: 0 pin, 1 watchdog
	localparam int EMR_SSE      = 0; // segment_save_enable
	localparam int VEC_BASE_LO  = 4; // software part of the vector
	localparam int EV_IRQ       = 0; // channel acknowledged
	localparam int EV_TL        = 1; // top level acknowledged
	localparam int EV_TRAP      = 2; // divide by zero trap taken

	// ----------------------------------------------------------------
	// counts, addresses and reset values
	// ----------------------------------------------------------------
	localparam int          N_PERIPH     = 4;
	localparam int          N_EXT        = 8;
	localparam int          N_EVENT      = 3;
	localparam logic [2:0]  CPL_RESET    = 3'h7;
	localparam logic [7:0]  ISEG_RESET   = 8'h00;
	localparam logic [7:0]  CSEG_RESET   = 8'h00;
	localparam logic [15:0] SP_RESET     = 16'h0000;
	localparam logic [7:0]  STACK_SEG    = 8'h00;
	localparam logic [23:0] RST_VEC_ADDR = 24'h000000;
	localparam logic [15:0] TRAP_VEC_OFS = 16'h0002;
	localparam logic [15:0] TL_VEC_OFS   = 16'h0004;
	localparam logic [7:0]  TABLE_PAGE   = 8'h00; // table sits in the first 256 bytes

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [12:0] {
		ST_IDLE     = 13'h0001,
		ST_PUSH_PCL = 13'h0002,
		ST_PUSH_PCH = 13'h0004,
		ST_PUSH_CS  = 13'h0008,
		ST_PUSH_FL  = 13'h0010,
		ST_VEC_RD0  = 13'h0020,
		ST_VEC_RD1  = 13'h0040,
		ST_VEC_LOAD = 13'h0080,
		ST_POP_FL   = 13'h0100,
		ST_POP_CS   = 13'h0200,
		ST_POP_PCH  = 13'h0400,
		ST_POP_PCL  = 13'h0800,
		ST_POP_END  = 13'h1000
	} seq_state_e;

	typedef enum logic [1:0] {
		KIND_RST  = 2'h0,
		KIND_IRQ  = 2'h1,
		KIND_TL   = 2'h2,
		KIND_TRAP = 2'h3
	} entry_kind_e;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} mem_req_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic pend;
	} edge_state_s;

endpackage

// >>> test/mem_model.sv
// behavioural memory on the far side of the vectoring unit
`timescale 1ns/100ps
module mem_model (
	input  wire logic                    clk,
	input  wire vectoring_pkg::mem_req_s req,
	output logic [7:0]                   rdata
);
	logic [7:0] mem [int];
	logic [7:0] last;
	initial begin
		mem[6] = 8'hff;
		mem[7] = 8'hff;
		rdata = 8'h00;
	end
	// store writes; answer a read in the next cycle only, garble otherwise
	always @(posedge clk) begin
		if (req.wr)
			mem[int'(req.addr)] = req.wdata;
		last = mem.exists(int'(req.addr)) ? mem[int'(req.addr)] :
			req.addr[7:0] ^ req.addr[15:8] ^ 8'ha5;
		rdata <= req.rd ? last : ~rdata;
	end
endmodule // mem_model

// >>> test/tb_top.sv
// self-checking bench of the interrupt vectoring unit
`timescale 1ns/100ps
module tb_top;
	logic                    clk, resetn, reg_wr, reg_rd, div_zero, iret, wdg_req, csr_wr;
	logic [7:0]              flags_value, ext_pin, fl, csr_wdata;
	logic                    pc_load, busy, irq;
	logic [7:0]              reg_addr, reg_wdata, reg_rdata, core_flags, code_seg, mem_rdata;
	logic [15:0]             core_pc, pc_value, ret_pc;
	logic [3:0]              periph_req, periph_ack;
	logic [3:0][2:0]         periph_prl;
	logic [3:0][7:0]         periph_vec;
	vectoring_pkg::mem_req_s mem_req;
	int                      seed = 32'h1dc1dd6c;
	int                      failures = 0;
	int                      total_checks = 0;
	int                      s;
	logic [15:0]             exp_q [$];

	interrupt_vectoring_unit interrupt_vectoring_unit_inst (.clk, .resetn, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_pc, .core_flags, .div_zero,
		.iret, .csr_wr, .csr_wdata, .pc_value, .pc_load, .flags_value,
		.flags_load(), .busy, .code_seg, .mem_req, .mem_rdata, .periph_req,
		.periph_prl, .periph_vec, .periph_ack, .ext_pin, .nmi_pin(1'b0),
		.wdg_req, .irq);
	mem_model mem_model_inst (.clk, .req(mem_req), .rdata(mem_rdata));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pointer word as the memory model holds it, high byte first
	function automatic logic [15:0] vec_at(logic [23:0] a);
		return {a[7:0] ^ a[15:8] ^ 8'ha5, a[7:0] ^ a[15:8] ^ 8'ha4};
	endfunction

	task chk(input logic [15:0] v, e);
		total_checks++;
		if (v !== e) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, v, e);
		end
	endtask

	task end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk);
	endtask

	// bounded wait for the new pc
	task waitpc();
		for (int n = 0; n < 60 && pc_load !== 1'b1; n++) @(negedge clk);
		if (pc_load !== 1'b1) begin
			failures++;
			end_sim();
		end
		@(posedge clk);
		#1;
	endtask

	// one core pulse: 1 return, 2 watchdog, 3 divide by zero
	task run(input int k, input logic [15:0] e);
		exp_q.push_back(e);
		iret <= (k == 1);
		wdg_req <= (k == 2);
		div_zero <= (k == 3);
		@(posedge clk);
		{iret, wdg_req, div_zero} <= 3'h0;
		waitpc();
	endtask

	// compare every loaded pc with the oldest note
	always @(negedge clk)
		if (pc_load === 1'b1)
			chk(pc_value, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);

	initial begin
		{reg_wr, reg_rd, div_zero, iret, wdg_req, periph_req, reg_addr, reg_wdata} = '0;
		{core_flags, core_pc, periph_prl, periph_vec, resetn, ext_pin, csr_wr, csr_wdata} = '0;
		exp_q.push_back(vec_at(24'h0));
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		waitpc();
		$display("reset fetch done");
		wr(8'h00, 8'h09);
		wr(8'h02, 8'h12);
		for (s = 0; s < 2; s++) begin
			wr(8'h01, s[7:0]);
			ret_pc = 16'($random(seed));
			core_pc <= ret_pc;
			fl = 8'($random(seed));
			core_flags <= fl;
			periph_vec[1] <= 8'($random(seed)) & 8'hfe;
			periph_prl[1] <= 3'h2;
			periph_req[1] <= 1'b1;
			@(posedge clk);
			exp_q.push_back(vec_at({16'h1200, periph_vec[1]}));
			#1 chk(periph_ack, 4'h2);
			waitpc();
			periph_req[1] <= 1'b0;
			chk(code_seg, 8'h12);
			csr_wdata <= 8'h34;
			csr_wr <= 1'b1;
			@(posedge clk);
			csr_wr <= 1'b0;
			run(1, ret_pc);
			chk(code_seg, 8'h00);
			chk(flags_value, fl);
		end
		periph_prl[1] <= 3'h4;
		periph_req[1] <= 1'b1;
		repeat (3) @(posedge clk);
		periph_req[1] <= 1'b0;
		#1 chk(busy, 1'b0);
		wr(8'h04, 8'h08);
		wr(8'h05, 8'h08);
		wr(8'h06, 8'h50);
		wr(8'h07, 8'h01);
		exp_q.push_back(vec_at(24'h120056));
		ext_pin[3] <= 1'b1;
		waitpc();
		run(1, ret_pc);
		$display("peripheral entry and return done");
		wr(8'h00, 8'h19);
		ret_pc = 16'($random(seed));
		core_pc <= ret_pc;
		run(2, vec_at(24'h120004));
		run(1, ret_pc);
		$display("top level done");
		run(3, vec_at(24'h000002));
		rd(8'h09, 8'h07);
		wr(8'h0a, 8'h04);
		chk(irq, 1'b1);
		wr(8'h09, 8'h07);
		chk(irq, 1'b0);
		rd(8'h3f, 8'h00);
		$display("trap and status done");
		end_sim();
	end
endmodule // tb_top
